/* core/sysclk_pkg.sv */
// package: register map, field layout, reset values, modes and timing for the clock mode control
// Contract
// - select field picks hs divided or ls clock
// - hs source bit picks rc or crystal
// - ls source bit picks rc or crystal
// - hs idle enable keeps hs osc in halt
// - ls idle enable keeps ls osc in halt
// - halt with both zero enters sleep
// - sleep keeps ls rc only with watchdog
// - halt with hs zero, ls one: idle_low_only
// - halt with both one: idle_both_osc
// - halt with hs one, ls zero: idle_high_only
// - slow mode hs clock follows osc enable
// - divided hs clocks stay while osc enabled
// - control bit four reads as zero
// - rc frequency field 8, 12, 16, 8 MHz
// - rc stable flag clears then sets on change
// - crystal stable flag clears then sets on enable
// - slow switch waits for ls osc stable
package sysclk_pkg;
	// register byte offsets on apb
	localparam logic [11:0] SYSCLK_OFF_CTRL  = 12'h000;
	localparam logic [11:0] SYSCLK_OFF_HS_RC = 12'h004;
	localparam logic [11:0] SYSCLK_OFF_HS_XT = 12'h008;
	localparam logic [11:0] SYSCLK_OFF_LS_XT = 12'h00C;
	localparam logic [11:0] SYSCLK_OFF_MODE  = 12'h010;
	// reset values
	localparam logic [7:0]  SYSCLK_RST_CTRL  = 8'h00;
	localparam logic [7:0]  SYSCLK_RST_HS_RC = 8'h01;
	localparam logic [7:0]  SYSCLK_RST_HS_XT = 8'h00;
	localparam logic [7:0]  SYSCLK_RST_LS_XT = 8'h04;
	// system clock control field positions
	localparam int SYSCLK_SEL_LSB     = 5;
	localparam int SYSCLK_HS_SRC_BIT  = 3;
	localparam int SYSCLK_LS_SRC_BIT  = 2;
	localparam int SYSCLK_HID_BIT  = 1;
	localparam int SYSCLK_LID_BIT  = 0;
	// select code meaning the low-speed clock
	localparam logic [2:0]  SYSCLK_SEL_LS    = 3'h7;
	// oscillator start-up times in ns
	localparam int SYSCLK_HS_START_NS = 1000;
	localparam int SYSCLK_LS_START_NS = 2000;
	localparam int SYSCLK_CLK_NS      = 5;
	localparam int SYSCLK_HS_START_CYC = (SYSCLK_HS_START_NS + SYSCLK_CLK_NS - 1) / SYSCLK_CLK_NS;
	localparam int SYSCLK_LS_START_CYC = (SYSCLK_LS_START_NS + SYSCLK_CLK_NS - 1) / SYSCLK_CLK_NS;
	// operating modes, one-hot
	typedef enum logic [5:0] {
		SYSCLK_FAST      = 6'h01,
		SYSCLK_SLOW      = 6'h02,
		SYSCLK_SLEEP     = 6'h04,
		SYSCLK_IDLE_LOW  = 6'h08,
		SYSCLK_IDLE_BOTH = 6'h10,
		SYSCLK_IDLE_HIGH = 6'h20
	} sysclk_mode_t;
	// oscillator run enables toward the analog side
	typedef struct packed {
		logic int_hs_rc;
		logic ext_hs_crystal;
		logic int_ls_rc;
		logic ext_ls_crystal;
	} sysclk_osc_t;
endpackage

/* core/sysclk_osc_ready.sv */
// module: start-up timer giving an oscillator stable flag
module sysclk_osc_ready
	import sysclk_pkg::*;
#(
	parameter int START_CYC = 200
)(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	// control
	input  wire logic run_i,
	input  wire logic restart_i,
	// status
	output logic      stable_o
);
	localparam int CW = $clog2(START_CYC + 1);
	logic [CW-1:0] count; // cycles since start

	// flag clears on start or restart and sets after the start-up time
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count    <= '0;
			stable_o <= 1'b0;
		end else if (!run_i || restart_i) begin
			count    <= '0;
			stable_o <= 1'b0;
		end else if (count == CW'(START_CYC - 1)) begin
			stable_o <= 1'b1;
		end else if (!stable_o) begin
			count <= count + 1'b1;
		end
	end

	a_ready_after: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(run_i && !restart_i && !stable_o) [*1] |-> ##[0:1000] (stable_o || !run_i || restart_i))
		else $error("oscillator never became stable");
endmodule

/* core/sysclk_ctrl.sv */
// module: system clock select, divider and halt mode control with apb registers
//
// The APB register port and the placing of the registers are this design's own decisions.
module sysclk_ctrl
	import sysclk_pkg::*;
#(
	parameter int HS_START_CYC = SYSCLK_HS_START_CYC,
	parameter int LS_START_CYC = SYSCLK_LS_START_CYC
)(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// cpu and watchdog side
	input  wire logic        halt_i,
	input  wire logic        wake_i,
	input  wire logic        wdt_enable_i,
	// clock enables toward consumers
	output logic             sys_clk_en_o,
	output logic             hs_clk_en_o,
	output logic             ls_clk_en_o,
	output logic             int_ls_rc_clk_en_o,
	output logic             cpu_run_o,
	output sysclk_osc_t      osc_run_o,
	output logic      [1:0]  hs_rc_freq_o
);
	// registers
	logic [2:0]   sysclk_select;      // divider / source code
	logic         hs_source_select;   // 0 rc, 1 crystal
	logic         ls_source_select;   // 0 rc, 1 crystal
	logic         hs_osc_idle_enable; // hs kept in halt
	logic         ls_osc_idle_enable; // ls kept in halt
	logic [1:0]   hs_rc_freq_select;
	logic         hs_rc_enable;
	logic         hs_crystal_range_mode;
	logic         hs_crystal_enable;
	logic         ls_crystal_enable;
	logic [2:0]   active_select;      // select code in effect
	sysclk_mode_t mode;
	// stable flags and pacing
	logic         hs_rc_stable_flag;
	logic         hs_crystal_stable_flag;
	logic         ls_crystal_stable_flag;
	logic         int_ls_rc_stable;
	logic         rc_restart;         // frequency change or enable pulse
	logic         hx_restart;
	logic         lx_restart;
	logic [5:0]   div_count;          // free running hs divider
	logic         hs_run;
	logic         ls_run;
	logic         in_idle;
	logic         ls_stable;
	logic         wr_en;
	logic         rd_en;
	logic [7:0]   rd_byte;
	logic         hit;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !pwrite;
	assign pready  = 1'b1;
	assign in_idle = (mode == SYSCLK_IDLE_LOW) || (mode == SYSCLK_IDLE_BOTH) || (mode == SYSCLK_IDLE_HIGH);

	// register writes
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{sysclk_select, hs_source_select, ls_source_select} <= {SYSCLK_RST_CTRL[7:5], SYSCLK_RST_CTRL[3:2]};
			{hs_osc_idle_enable, ls_osc_idle_enable}            <= SYSCLK_RST_CTRL[1:0];
			{hs_rc_freq_select, hs_rc_enable}                   <= {SYSCLK_RST_HS_RC[3:2], SYSCLK_RST_HS_RC[0]};
			{hs_crystal_range_mode, hs_crystal_enable}          <= {SYSCLK_RST_HS_XT[2], SYSCLK_RST_HS_XT[0]};
			ls_crystal_enable                                   <= SYSCLK_RST_LS_XT[0];
		end else if (wr_en) begin
			unique case (paddr)
				SYSCLK_OFF_CTRL: begin
					sysclk_select      <= pwdata[SYSCLK_SEL_LSB +: 3];
					hs_source_select   <= pwdata[SYSCLK_HS_SRC_BIT];
					ls_source_select   <= pwdata[SYSCLK_LS_SRC_BIT];
					hs_osc_idle_enable <= pwdata[SYSCLK_HID_BIT];
					ls_osc_idle_enable <= pwdata[SYSCLK_LID_BIT];
				end
				SYSCLK_OFF_HS_RC: begin
					hs_rc_freq_select <= pwdata[3:2];
					hs_rc_enable      <= pwdata[0];
				end
				SYSCLK_OFF_HS_XT: begin
					// range mode is frozen while the crystal runs
					if (!hs_crystal_enable) begin
						hs_crystal_range_mode <= pwdata[2];
					end
					hs_crystal_enable <= pwdata[0];
				end
				SYSCLK_OFF_LS_XT: begin
					ls_crystal_enable <= pwdata[0];
				end
				default: begin
				end
			endcase
		end
	end

	// restart pulses on enable rise or frequency change
	assign rc_restart = wr_en && (paddr == SYSCLK_OFF_HS_RC) &&
		((pwdata[0] && !hs_rc_enable) || (pwdata[3:2] != hs_rc_freq_select));
	assign hx_restart = wr_en && (paddr == SYSCLK_OFF_HS_XT) && pwdata[0] && !hs_crystal_enable;
	assign lx_restart = wr_en && (paddr == SYSCLK_OFF_LS_XT) && pwdata[0] && !ls_crystal_enable;

	// oscillator run decisions per mode
	always_comb begin
		hs_run = 1'b0;
		ls_run = 1'b0;
		unique case (mode)
			SYSCLK_FAST:      begin hs_run = 1'b1; ls_run = 1'b1; end
			SYSCLK_SLOW:      begin hs_run = 1'b1; ls_run = 1'b1; end // hs gated by its enable below
			SYSCLK_SLEEP:     begin hs_run = 1'b0; ls_run = 1'b0; end
			SYSCLK_IDLE_LOW:  begin hs_run = 1'b0; ls_run = 1'b1; end
			SYSCLK_IDLE_BOTH: begin hs_run = 1'b1; ls_run = 1'b1; end
			SYSCLK_IDLE_HIGH: begin hs_run = 1'b1; ls_run = 1'b0; end
			default:          begin hs_run = 1'b0; ls_run = 1'b0; end
		endcase
	end

	// oscillator enables: hs follows its own enable bit, ls rc also kept for watchdog in sleep
	always_comb begin
		osc_run_o.int_hs_rc      = hs_run && hs_rc_enable && !hs_source_select;
		osc_run_o.ext_hs_crystal = hs_run && hs_crystal_enable && hs_source_select;
		osc_run_o.ext_ls_crystal = ls_run && ls_crystal_enable && ls_source_select;
		osc_run_o.int_ls_rc      = (ls_run && !ls_source_select) ||
			(mode == SYSCLK_SLEEP && wdt_enable_i);
	end

	sysclk_osc_ready #(.START_CYC(HS_START_CYC)) u_rc_ready (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.run_i     (osc_run_o.int_hs_rc),
		.restart_i (rc_restart),
		.stable_o  (hs_rc_stable_flag)
	);
	sysclk_osc_ready #(.START_CYC(HS_START_CYC)) u_hx_ready (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.run_i     (osc_run_o.ext_hs_crystal),
		.restart_i (hx_restart),
		.stable_o  (hs_crystal_stable_flag)
	);
	sysclk_osc_ready #(.START_CYC(LS_START_CYC)) u_lx_ready (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.run_i     (osc_run_o.ext_ls_crystal),
		.restart_i (lx_restart),
		.stable_o  (ls_crystal_stable_flag)
	);
	sysclk_osc_ready #(.START_CYC(LS_START_CYC)) u_lr_ready (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.run_i     (osc_run_o.int_ls_rc),
		.restart_i (1'b0),
		.stable_o  (int_ls_rc_stable)
	);
	assign ls_stable = ls_source_select ? ls_crystal_stable_flag : int_ls_rc_stable;

	// mode machine: halt picks sleep or idle, select code picks fast or slow
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode          <= SYSCLK_FAST;
			active_select <= SYSCLK_RST_CTRL[7:5];
		end else begin
			unique case (mode)
				SYSCLK_FAST, SYSCLK_SLOW: begin
					if (halt_i) begin
						unique case ({hs_osc_idle_enable, ls_osc_idle_enable})
							2'b00: mode <= SYSCLK_SLEEP;
							2'b01: mode <= SYSCLK_IDLE_LOW;
							2'b11: mode <= SYSCLK_IDLE_BOTH;
							2'b10: mode <= SYSCLK_IDLE_HIGH;
						endcase
					end else if (sysclk_select == SYSCLK_SEL_LS) begin
						// hold the old clock until the ls source is stable
						if (ls_stable) begin
							mode          <= SYSCLK_SLOW;
							active_select <= sysclk_select;
						end
					end else begin
						mode          <= SYSCLK_FAST;
						active_select <= sysclk_select;
					end
				end
				default: begin
					if (wake_i) begin
						mode <= (active_select == SYSCLK_SEL_LS) ? SYSCLK_SLOW : SYSCLK_FAST;
					end
				end
			endcase
		end
	end

	// free running hs prescaler
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + 1'b1;
		end
	end

	// clock enable outputs
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sys_clk_en_o       <= 1'b0;
			hs_clk_en_o        <= 1'b0;
			ls_clk_en_o        <= 1'b0;
			int_ls_rc_clk_en_o <= 1'b0;
			cpu_run_o          <= 1'b0;
		end else begin
			hs_clk_en_o        <= osc_run_o.int_hs_rc || osc_run_o.ext_hs_crystal;
			ls_clk_en_o        <= ls_run && ls_stable;
			int_ls_rc_clk_en_o <= osc_run_o.int_ls_rc;
			cpu_run_o          <= (mode == SYSCLK_FAST) || (mode == SYSCLK_SLOW);
			if (mode == SYSCLK_SLEEP) begin
				sys_clk_en_o <= 1'b0;
			end else if (active_select == SYSCLK_SEL_LS) begin
				sys_clk_en_o <= ls_stable && (!in_idle || ls_osc_idle_enable);
			end else begin
				// divide by two to the power of the code
				sys_clk_en_o <= ((div_count & ((6'h01 << active_select) - 6'h01)) == 6'h00) &&
					(osc_run_o.int_hs_rc || osc_run_o.ext_hs_crystal) &&
					(!in_idle || hs_osc_idle_enable);
			end
		end
	end

	// read mux, bit four of the control register always zero
	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr)
			SYSCLK_OFF_CTRL:  rd_byte = {sysclk_select, 1'b0, hs_source_select, ls_source_select,
				hs_osc_idle_enable, ls_osc_idle_enable};
			SYSCLK_OFF_HS_RC: rd_byte = {4'h0, hs_rc_freq_select, hs_rc_stable_flag, hs_rc_enable};
			SYSCLK_OFF_HS_XT: rd_byte = {5'h00, hs_crystal_range_mode, hs_crystal_stable_flag, hs_crystal_enable};
			SYSCLK_OFF_LS_XT: rd_byte = {5'h00, 1'b1, ls_crystal_stable_flag, ls_crystal_enable};
			SYSCLK_OFF_MODE: rd_byte = {2'h0, mode};
			default:         hit = 1'b0;
		endcase
	end

	// read data and error registered in the setup cycle
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !hit;
		end
	end

	assign hs_rc_freq_o = hs_rc_freq_select; // 00/11 8 MHz, 01 12 MHz, 10 16 MHz

	a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(cpu_run_o && (mode != SYSCLK_SLEEP) && halt_i && !hs_osc_idle_enable && !ls_osc_idle_enable
		&& (mode == SYSCLK_FAST || mode == SYSCLK_SLOW)) |=> (mode == SYSCLK_SLEEP))
		else $error("halt with idle bits clear did not sleep");
	a_sleep_oscs_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == SYSCLK_SLEEP) |-> !osc_run_o.ext_hs_crystal && !osc_run_o.int_hs_rc
		&& !osc_run_o.ext_ls_crystal && (osc_run_o.int_ls_rc == wdt_enable_i))
		else $error("oscillator left running in sleep");
	a_idle_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		((mode == SYSCLK_FAST) && halt_i && !hs_osc_idle_enable && ls_osc_idle_enable)
		|=> (mode == SYSCLK_IDLE_LOW) ##1 (!hs_clk_en_o))
		else $error("idle low only entry wrong");
	a_idle_both: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		((mode == SYSCLK_FAST) && halt_i && hs_osc_idle_enable && ls_osc_idle_enable)
		|=> (mode == SYSCLK_IDLE_BOTH))
		else $error("idle both entry wrong");
	a_idle_high: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == SYSCLK_IDLE_HIGH) |-> !osc_run_o.ext_ls_crystal)
		else $error("ls crystal running in idle high only");
	a_slow_waits: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$rose(mode == SYSCLK_SLOW) |-> $past(ls_stable))
		else $error("slow mode entered before ls stable");
	a_ctrl_bit4: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(rd_en && !penable && paddr == SYSCLK_OFF_CTRL) |=> !prdata[4])
		else $error("control bit four read as one");
	a_rc_flag_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		rc_restart |=> !hs_rc_stable_flag)
		else $error("rc stable flag did not clear");
	// the enable in hand must come from the halving code too, not from the code before it
	a_div_select: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mode == SYSCLK_FAST && active_select == 3'h1 && $past(active_select) == 3'h1 && sys_clk_en_o)
		|=> !sys_clk_en_o)
		else $error("divide by two enable wrong");
	c_sleep: cover property (@(posedge ref_clk_i) mode == SYSCLK_SLEEP);
	c_slow: cover property (@(posedge ref_clk_i) mode == SYSCLK_SLOW);
	c_idle_both: cover property (@(posedge ref_clk_i) mode == SYSCLK_IDLE_BOTH);
	c_wake: cover property (@(posedge ref_clk_i) in_idle && wake_i);
endmodule

/* testbench/sysclk_cpu_model.sv */
// partner model: cpu core issuing halt and a peripheral counting system clock enables
module sysclk_cpu_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// requests from the bench
	input  wire logic        halt_req_i,
	input  wire logic        tick_clr_i,
	// block outputs watched
	input  wire logic        sys_clk_en_i,
	input  wire logic        cpu_run_i,
	// toward the block and the bench
	output logic             halt_o,
	output logic      [15:0] ticks_o
);
	logic req_d; // request level one cycle ago

	// halt is an instruction, so it only issues while the cpu is clocked
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_d  <= 1'h0;
			halt_o <= 1'h0;
		end else begin
			req_d  <= halt_req_i;
			halt_o <= halt_req_i & ~req_d & cpu_run_i;
		end
	end

	// a peripheral counts the system clock enables it receives
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ticks_o <= 16'h0000;
		end else if (tick_clr_i) begin
			ticks_o <= 16'h0000;
		end else begin
			ticks_o <= ticks_o + {15'h0000, sys_clk_en_i};
		end
	end
endmodule

/* testbench/tb.sv */
// testbench: apb register access, divider, sources, slow switch and halt modes
module tb import sysclk_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int START = 8; // short oscillator start-up
	logic        ref_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        halt_i, wake_i, wdt_enable_i, halt_req, tick_clr;
	logic        sys_clk_en_o, hs_clk_en_o, ls_clk_en_o, int_ls_rc_clk_en_o, cpu_run_o;
	sysclk_osc_t osc_run_o;
	logic [1:0]  hs_rc_freq_o;
	logic [15:0] ticks;
	int          err_count, total_checks;

	sysclk_ctrl #(.HS_START_CYC(START), .LS_START_CYC(START)) i_sysclk_ctrl (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_i(halt_i), .wake_i(wake_i), .wdt_enable_i(wdt_enable_i), .sys_clk_en_o(sys_clk_en_o),
		.hs_clk_en_o(hs_clk_en_o), .ls_clk_en_o(ls_clk_en_o), .int_ls_rc_clk_en_o(int_ls_rc_clk_en_o),
		.cpu_run_o(cpu_run_o), .osc_run_o(osc_run_o), .hs_rc_freq_o(hs_rc_freq_o));
	sysclk_cpu_model i_sysclk_cpu_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .halt_req_i(halt_req),
		.tick_clr_i(tick_clr), .sys_clk_en_i(sys_clk_en_o), .cpu_run_i(cpu_run_o), .halt_o(halt_i),
		.ticks_o(ticks));

	// 200 MHz clock
	initial begin
		ref_clk_i = 1'h0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// compare one value, report at once on mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, then access until pready at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic e);
		int n;
		@(posedge ref_clk_i);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk_i);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		e  = pslverr;
		if (pready !== 1'h1) begin
			err_count++;
			$display("wrong value at %0t: no ready on the register bus", $time);
			test_done();
		end
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// register write and checked read
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic        e;
		apb(1'h1, a, d, v, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic        e;
		apb(1'h0, a, 32'h0, v, e);
		chk(v, exp);
	endtask

	// poll the mode register with a bounded count
	task automatic wait_mode(input logic [31:0] m);
		logic [31:0] v;
		logic        e;
		for (int n = 0; n < 60; n++) begin
			apb(1'h0, SYSCLK_OFF_MODE, 32'h0, v, e);
			if (v === m) break;
		end
		chk(v, m);
		// a mode that never comes ends the run here
		if (v !== m) begin
			test_done();
		end
	endtask

	// system clock enables seen by a peripheral over 128 cycles
	task automatic cnt(output logic [15:0] c);
		@(posedge ref_clk_i);
		tick_clr <= 1'h1;
		@(posedge ref_clk_i);
		tick_clr <= 1'h0;
		repeat (129) @(posedge ref_clk_i);
		c = ticks;
	endtask

	// reset values, read-only bits and an unmapped address
	task automatic t_reset();
		logic [31:0] v;
		logic        e;
		repeat (20) @(posedge ref_clk_i);
		rd(SYSCLK_OFF_CTRL, 32'h00);
		rd(SYSCLK_OFF_HS_RC, 32'h03);
		rd(SYSCLK_OFF_HS_XT, 32'h00);
		rd(SYSCLK_OFF_LS_XT, 32'h04);
		rd(SYSCLK_OFF_MODE, 32'h01);
		apb(1'h0, 12'h014, 32'h0, v, e);
		chk(v, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(SYSCLK_OFF_CTRL, 32'h13);
		rd(SYSCLK_OFF_CTRL, 32'h03);
		wr(SYSCLK_OFF_CTRL, 32'h00);
		$display("test reset done");
	endtask

	// every divide code on the internal rc
	task automatic t_divide();
		logic [15:0] c;
		for (int k = 0; k < 7; k++) begin
			wr(SYSCLK_OFF_CTRL, {24'h0, k[2:0], 5'h00});
			cnt(c);
			chk({16'h0, c}, 32'h80 >> k);
		end
		wr(SYSCLK_OFF_CTRL, 32'h00);
		$display("test divide done");
	endtask

	// crystal as hs source, its stable flag, rc frequency codes
	task automatic t_sources();
		logic [15:0] c;
		wr(SYSCLK_OFF_CTRL, 32'h08);
		repeat (4) @(posedge ref_clk_i);
		chk({31'h0, hs_clk_en_o}, 32'h0);
		wr(SYSCLK_OFF_HS_XT, 32'h01);
		rd(SYSCLK_OFF_HS_XT, 32'h01);
		repeat (20) @(posedge ref_clk_i);
		rd(SYSCLK_OFF_HS_XT, 32'h03);
		chk({31'h0, osc_run_o.ext_hs_crystal}, 32'h1);
		cnt(c);
		chk({16'h0, c}, 32'h80);
		wr(SYSCLK_OFF_CTRL, 32'h00);
		wr(SYSCLK_OFF_HS_XT, 32'h00);
		for (int k = 1; k < 5; k++) begin
			wr(SYSCLK_OFF_HS_RC, {28'h0, k[1:0], 2'h1});
			rd(SYSCLK_OFF_HS_RC, {28'h0, k[1:0], 2'h1});
			repeat (20) @(posedge ref_clk_i);
			rd(SYSCLK_OFF_HS_RC, {28'h0, k[1:0], 2'h3});
			chk({30'h0, hs_rc_freq_o}, {30'h0, k[1:0]});
		end
		$display("test sources done");
	endtask

	// slow switch waits for the crystal, hs clock follows its enable
	task automatic t_slow();
		wr(SYSCLK_OFF_CTRL, 32'hE4);
		repeat (20) @(posedge ref_clk_i);
		rd(SYSCLK_OFF_MODE, 32'h01);
		wr(SYSCLK_OFF_LS_XT, 32'h01);
		wait_mode(32'h02);
		chk({31'h0, osc_run_o.ext_ls_crystal}, 32'h1);
		chk({31'h0, hs_clk_en_o}, 32'h1);
		wr(SYSCLK_OFF_HS_RC, 32'h00);
		repeat (4) @(posedge ref_clk_i);
		chk({31'h0, hs_clk_en_o}, 32'h0);
		chk({31'h0, osc_run_o.int_hs_rc}, 32'h0);
		wr(SYSCLK_OFF_HS_RC, 32'h01);
		wr(SYSCLK_OFF_CTRL, 32'h00);
		repeat (30) @(posedge ref_clk_i);
		wait_mode(32'h01);
		$display("test slow done");
	endtask

	// all four halt modes, sleep twice for the watchdog
	task automatic t_halt();
		logic [15:0] c;
		logic [31:0] modes [4] = '{32'h04, 32'h08, 32'h20, 32'h10};
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_i);
			wdt_enable_i <= (i == 4);
			wr(SYSCLK_OFF_CTRL, {30'h0, i[1:0]});
			@(posedge ref_clk_i);
			halt_req <= 1'h1;
			@(posedge ref_clk_i);
			halt_req <= 1'h0;
			repeat (4) @(posedge ref_clk_i);
			chk({31'h0, cpu_run_o}, 32'h0);
			rd(SYSCLK_OFF_MODE, modes[i[1:0]]);
			chk({31'h0, hs_clk_en_o}, {31'h0, i[1]});
			chk({31'h0, ls_clk_en_o}, {31'h0, i[0]});
			if (i[1:0] == 2'h0) chk({31'h0, int_ls_rc_clk_en_o}, {31'h0, i == 4});
			cnt(c);
			chk({31'h0, c != 16'h0}, {31'h0, i[1]});
			@(posedge ref_clk_i);
			wake_i <= 1'h1;
			@(posedge ref_clk_i);
			wake_i <= 1'h0;
			wait_mode(32'h01);
			repeat (30) @(posedge ref_clk_i);
		end
		$display("test halt done");
	endtask

	// reset, then scenarios in order
	initial begin
		{nrst_i, psel, penable, pwrite, wake_i, wdt_enable_i, halt_req, tick_clr} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_count = 0;
		total_checks = 0;
		repeat (4) @(posedge ref_clk_i);
		nrst_i <= 1'h1;
		t_reset();
		t_divide();
		t_sources();
		t_slow();
		t_halt();
		test_done();
	end
endmodule
